/* File: design/two_level_interrupt_handler.sv */
// two-level vectored interrupt handler: pending flags, masking, arbitration and nesting
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - eighteen independent sources, each with a software-visible pending flag.
// - a source's trigger event sets its pending flag to one.
// - flags set on their trigger regardless of any enable.
// - a set flag with its source enabled raises a request to the core.
// - after the current instruction the core long-calls the source's fixed vector.
// - return-from-interrupt resumes the program and ends the current service level.
// - a disabled source's flag is ignored for requests; the program runs on.
// - each source has its own enable bit in the enable registers.
// - global enable bit 7 of the main enable register masks every source when zero.
// - flags set while globally disabled stay pending until enabled again.
// - some flags clear automatically on vectoring; others wait for software.
// - a flag still set after return re-requests after exactly one instruction.
// - software writing one to a flag sets it like a hardware event, but two cycles sooner, skipping the resync.
// - each source is low or high level; high preempts a low routine.
// - nothing preempts an active high-level routine.
// - every priority bit resets to low.
// - simultaneous requests of different levels: the high one wins.
// - equal-level ties resolve by fixed source order, lowest index first.
// - requests sampled and decoded every cycle; best latency seven cycles.
// - a request pending at return waits for one more instruction.
// - equal or lower level requests wait for return plus one instruction.
module two_level_interrupt_handler #(
    parameter int unsigned sources = irq_pkg::num_sources
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [sources-1:0] src_event,
    input wire logic [sources-1:0] flag_set_wr,
    input wire logic [sources-1:0] flag_clr_wr,
    input wire logic sfr_wr_en,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wr_data,
    output logic [7:0] sfr_rd_data,
    input wire logic instr_done,
    input wire logic return_from_interrupt,
    output logic irq_request,
    output logic [15:0] irq_vector,
    input wire logic long_call_to_vector,
    output logic [sources-1:0] pending_flags,
    output logic [1:0] service_level,
    output logic global_irq_enable
);
    if (sources != irq_pkg::num_sources) begin : g_bad_sources
        $error("sources must equal the register layout width");
    end

    typedef struct packed {
        logic [sources-1:0] pend;
        logic [sources-1:0] ev_s1;
        logic [sources-1:0] ev_s2;
        logic low_active;
        logic high_active;
        logic hold_one;
        logic req;
        logic [4:0] sel;
        logic sel_high;
        logic [15:0] vec;
    } core_state_t;

    core_state_t st_ff;
    core_state_t nxt_st;

    irq_sfr_if sfr ();
    assign sfr.wr_en = sfr_wr_en;
    assign sfr.addr = sfr_addr;
    assign sfr.wr_data = sfr_wr_data;

    irq_sfr_regs u_regs (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .bus(sfr)
    );

    logic [23:0] en_all;
    logic [23:0] pr_all;
    logic [sources-1:0] enabled;
    logic [sources-1:0] cand_high;
    logic [sources-1:0] cand_low;
    logic global_en;
    logic may_high;
    logic may_low;
    logic pick_valid;
    logic pick_high;
    logic [4:0] pick_idx;

    // main bit 7 is the global enable, so source 7 starts the first extended byte
    assign en_all = {1'b0, sfr.enable_ext_b, sfr.enable_ext_a, sfr.global_and_main[6:0]};
    assign pr_all = {1'b0, sfr.priority_ext_b, sfr.priority_ext_a, sfr.priority_main[6:0]};
    assign global_en = sfr.global_and_main[irq_pkg::global_enable_bit];

    // per-source gating: flag, own enable and global enable together
    for (genvar i = 0; i < sources; i++) begin : g_gate
        assign enabled[i] = st_ff.pend[i] & en_all[i] & global_en;
        assign cand_high[i] = enabled[i] & pr_all[i];
        assign cand_low[i] = enabled[i] & ~pr_all[i];
    end

    // preemption: high only over idle or low, low only over idle
    assign may_high = ~st_ff.high_active;
    assign may_low = ~st_ff.high_active & ~st_ff.low_active;

    always_comb begin
        pick_valid = 1'b0;
        pick_high = 1'b0;
        pick_idx = 5'h00;
        // descending scan so the lowest index is the last and winning assignment
        for (int k = sources - 1; k >= 0; k--) begin
            if (cand_low[k] && may_low && !pick_high) begin
                pick_valid = 1'b1;
                pick_idx = 5'(k);
            end
        end
        for (int k = sources - 1; k >= 0; k--) begin
            if (cand_high[k] && may_high) begin
                pick_valid = 1'b1;
                pick_high = 1'b1;
                pick_idx = 5'(k);
            end
        end
    end

    always_comb begin
        nxt_st = st_ff;
        // event inputs come from other peripherals' logic and are resynchronised
        nxt_st.ev_s1 = src_event;
        nxt_st.ev_s2 = st_ff.ev_s1;
        for (int k = 0; k < sources; k++) begin
            if (flag_clr_wr[k]) begin
                nxt_st.pend[k] = 1'b0;
            end
            if (long_call_to_vector && st_ff.req && st_ff.sel == 5'(k) && irq_pkg::auto_clear_mask[k]) begin
                nxt_st.pend[k] = 1'b0;
            end
            // set wins over any clear in the same cycle
            if (st_ff.ev_s2[k] || flag_set_wr[k]) begin
                nxt_st.pend[k] = 1'b1;
            end
        end
        if (long_call_to_vector && st_ff.req) begin
            // entering the routine: raise the level and drop the request
            nxt_st.req = 1'b0;
            if (st_ff.sel_high) begin
                nxt_st.high_active = 1'b1;
            end else begin
                nxt_st.low_active = 1'b1;
            end
        end else if (return_from_interrupt) begin
            // release the innermost level first
            if (st_ff.high_active) begin
                nxt_st.high_active = 1'b0;
            end else begin
                nxt_st.low_active = 1'b0;
            end
            nxt_st.hold_one = 1'b1;
            nxt_st.req = 1'b0;
        end else if (st_ff.hold_one) begin
            if (instr_done) begin
                nxt_st.hold_one = 1'b0;
            end
            nxt_st.req = 1'b0;
        end else begin
            // re-decoded every cycle until the core takes the call
            nxt_st.req = pick_valid;
            nxt_st.sel = pick_idx;
            nxt_st.sel_high = pick_high;
            nxt_st.vec = irq_pkg::vector_base + 16'(pick_idx) * 16'(irq_pkg::vector_stride);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sfr_rd_data = sfr.rd_data;
    assign irq_request = st_ff.req;
    assign irq_vector = st_ff.vec;
    assign pending_flags = st_ff.pend;
    assign service_level = st_ff.high_active ? irq_pkg::lvl_high
        : (st_ff.low_active ? irq_pkg::lvl_low : irq_pkg::lvl_idle);
    assign global_irq_enable = global_en;
endmodule // two_level_interrupt_handler
`default_nettype wire

/* File: design/irq_pkg.sv */
// package: register map, field positions, reset values and timing counts of the interrupt handler
package irq_pkg;
    localparam int unsigned num_sources = 18;
    localparam logic [7:0] addr_enable_main = 8'hA8;
    localparam logic [7:0] addr_priority_main = 8'hB8;
    localparam logic [7:0] addr_enable_ext_a = 8'hE6;
    localparam logic [7:0] addr_enable_ext_b = 8'hE7;
    localparam logic [7:0] addr_priority_ext_a = 8'hF6;
    localparam logic [7:0] addr_priority_ext_b = 8'hF7;
    localparam logic [7:0] rst_enable_main = 8'h00;
    localparam logic [7:0] rst_enable_ext = 8'h00;
    localparam logic [7:0] rst_priority = 8'h00;
    localparam logic [7:0] rd_priority_main_fixed = 8'h80;
    localparam int unsigned global_enable_bit = 7;
    localparam logic [15:0] vector_base = 16'h0003;
    localparam int unsigned vector_stride = 8;
    localparam logic [17:0] auto_clear_mask = 18'h0000F;
    localparam int unsigned detect_cycles = 1;
    localparam int unsigned call_cycles = 5;
    localparam int unsigned best_latency_cycles = 7;
    typedef enum logic [1:0] {
        lvl_idle = 2'b00,
        lvl_low = 2'b01,
        lvl_high = 2'b11
    } level_t;
endpackage

/* File: design/irq_sfr_if.sv */
// interface: special-function-register access port between the handler and its register file
`timescale 1ns/10ps
`default_nettype none
interface irq_sfr_if;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] global_and_main;
    logic [7:0] enable_ext_a;
    logic [7:0] enable_ext_b;
    logic [7:0] priority_main;
    logic [7:0] priority_ext_a;
    logic [7:0] priority_ext_b;
    modport regs (input wr_en, input addr, input wr_data, output rd_data, output global_and_main,
        output enable_ext_a, output enable_ext_b, output priority_main, output priority_ext_a,
        output priority_ext_b);
    modport core (output wr_en, output addr, output wr_data, input rd_data, input global_and_main,
        input enable_ext_a, input enable_ext_b, input priority_main, input priority_ext_a,
        input priority_ext_b);
endinterface
`default_nettype wire

/* File: design/irq_sfr_regs.sv */
// enable and priority register file of the interrupt handler
`timescale 1ns/10ps
`default_nettype none
module irq_sfr_regs (
    input wire logic ref_clk,
    input wire logic rst_n,
    irq_sfr_if.regs bus
);
    typedef struct packed {
        logic [7:0] en_main;
        logic [7:0] en_a;
        logic [7:0] en_b;
        logic [7:0] pr_main;
        logic [7:0] pr_a;
        logic [7:0] pr_b;
        logic [7:0] rd;
    } regs_state_t;

    regs_state_t st_ff;
    regs_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (bus.wr_en) begin
            case (bus.addr)
                irq_pkg::addr_enable_main: nxt_st.en_main = bus.wr_data;
                irq_pkg::addr_enable_ext_a: nxt_st.en_a = bus.wr_data;
                irq_pkg::addr_enable_ext_b: nxt_st.en_b = bus.wr_data;
                // top bit unused, held at zero internally
                irq_pkg::addr_priority_main: nxt_st.pr_main = {1'b0, bus.wr_data[6:0]};
                irq_pkg::addr_priority_ext_a: nxt_st.pr_a = bus.wr_data;
                irq_pkg::addr_priority_ext_b: nxt_st.pr_b = bus.wr_data;
                default: nxt_st.en_main = st_ff.en_main;
            endcase
        end
        // read data reflect the state after any write in the same cycle
        case (bus.addr)
            irq_pkg::addr_enable_main: nxt_st.rd = nxt_st.en_main;
            irq_pkg::addr_enable_ext_a: nxt_st.rd = nxt_st.en_a;
            irq_pkg::addr_enable_ext_b: nxt_st.rd = nxt_st.en_b;
            irq_pkg::addr_priority_main: nxt_st.rd = nxt_st.pr_main | irq_pkg::rd_priority_main_fixed;
            irq_pkg::addr_priority_ext_a: nxt_st.rd = nxt_st.pr_a;
            irq_pkg::addr_priority_ext_b: nxt_st.rd = nxt_st.pr_b;
            default: nxt_st.rd = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{en_main: irq_pkg::rst_enable_main, en_a: irq_pkg::rst_enable_ext,
                en_b: irq_pkg::rst_enable_ext, pr_main: irq_pkg::rst_priority,
                pr_a: irq_pkg::rst_priority, pr_b: irq_pkg::rst_priority, rd: 8'h00};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bus.rd_data = st_ff.rd;
    assign bus.global_and_main = st_ff.en_main;
    assign bus.enable_ext_a = st_ff.en_a;
    assign bus.enable_ext_b = st_ff.en_b;
    assign bus.priority_main = st_ff.pr_main;
    assign bus.priority_ext_a = st_ff.pr_a;
    assign bus.priority_ext_b = st_ff.pr_b;
endmodule // irq_sfr_regs
`default_nettype wire

/* File: tb/cpu_core_model.sv */
// core sequencer model: instruction boundaries, vector calls and returns
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic irq_request,
    input wire logic ret_cmd,
    input wire logic slow,
    output logic instr_done,
    output logic long_call_to_vector,
    output logic return_from_interrupt
);
    logic [1:0] cnt_ff;
    // slow mode ends an instruction every fourth cycle, so calls also come late
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 2'h0;
            instr_done <= 1'b0;
            long_call_to_vector <= 1'b0;
            return_from_interrupt <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 2'h1;
            instr_done <= !slow || cnt_ff == 2'h3;
            long_call_to_vector <= irq_request && instr_done && !long_call_to_vector;
            return_from_interrupt <= ret_cmd;
        end
    end
endmodule // cpu_core_model
`default_nettype wire

/* File: tb/two_level_interrupt_handler_chk.sv */
// assertions on the ports of the interrupt handler
`timescale 1ns/10ps
`default_nettype none
module two_level_interrupt_handler_chk #(
    parameter int unsigned sources = irq_pkg::num_sources
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [sources-1:0] src_event,
    input wire logic [sources-1:0] flag_set_wr,
    input wire logic return_from_interrupt,
    input wire logic irq_request,
    input wire logic [15:0] irq_vector,
    input wire logic long_call_to_vector,
    input wire logic [sources-1:0] pending_flags,
    input wire logic [1:0] service_level,
    input wire logic global_irq_enable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_event_sets_flag: assert property (src_event[9] |-> ##[1:4] pending_flags[9])
        else $error("event lost");
    a_write_sets_flag: assert property (flag_set_wr[6] |=> pending_flags[6])
        else $error("flag write lost");
    a_global_masks: assert property (!global_irq_enable [*2] |-> !irq_request)
        else $error("masked request");
    a_high_not_preempted: assert property (service_level == irq_pkg::lvl_high |-> !irq_request)
        else $error("high preempted");
    a_call_drops_req: assert property (long_call_to_vector && irq_request |=> !irq_request)
        else $error("request stays");
    a_call_sets_level: assert property (long_call_to_vector && irq_request |=>
        service_level != irq_pkg::lvl_idle) else $error("no level");
    a_vector_form: assert property (irq_request |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h008B)
        else $error("bad vector");
    a_return_ends_low: assert property (return_from_interrupt && service_level == irq_pkg::lvl_low
        |=> service_level == irq_pkg::lvl_idle) else $error("level kept");
    a_return_waits: assert property (return_from_interrupt |=> !irq_request [*2])
        else $error("early re-request");
    a_auto_clear: assert property (long_call_to_vector && irq_request && irq_vector == 16'h001B
        |=> !pending_flags[3]) else $error("flag not cleared");
endmodule // two_level_interrupt_handler_chk
bind two_level_interrupt_handler two_level_interrupt_handler_chk #(.sources(sources)) chk_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .src_event(src_event), .flag_set_wr(flag_set_wr), .return_from_interrupt(return_from_interrupt),
    .irq_request(irq_request), .irq_vector(irq_vector), .long_call_to_vector(long_call_to_vector),
    .pending_flags(pending_flags), .service_level(service_level), .global_irq_enable(global_irq_enable));
`default_nettype wire

/* File: tb/two_level_interrupt_handler_bench.sv */
// self-checking bench of the interrupt handler with a core model
`timescale 1ns/10ps
`default_nettype none
module two_level_interrupt_handler_bench;
    logic ref_clk = 1'b0, rst_n = 1'b0, sfr_wr_en = 1'b0, ret_cmd = 1'b0, slow = 1'b0;
    logic [17:0] src_event = '0, flag_set_wr = '0, flag_clr_wr = '0, pending_flags;
    logic [7:0] sfr_addr = 8'h00, sfr_wr_data = 8'h00, sfr_rd_data, d;
    logic instr_done, return_from_interrupt, irq_request, long_call_to_vector, global_irq_enable;
    logic [15:0] irq_vector;
    logic [1:0] service_level;
    logic [15:0] exp_q[$];
    int error_cnt = 0, check_count = 0;
    always #4 ref_clk = ~ref_clk;
    two_level_interrupt_handler two_level_interrupt_handler_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .src_event(src_event), .flag_set_wr(flag_set_wr), .flag_clr_wr(flag_clr_wr), .sfr_wr_en(sfr_wr_en),
        .sfr_addr(sfr_addr), .sfr_wr_data(sfr_wr_data), .sfr_rd_data(sfr_rd_data), .instr_done(instr_done),
        .return_from_interrupt(return_from_interrupt), .irq_request(irq_request), .irq_vector(irq_vector),
        .long_call_to_vector(long_call_to_vector), .pending_flags(pending_flags), .service_level(service_level),
        .global_irq_enable(global_irq_enable));
    cpu_core_model cpu_core_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .irq_request(irq_request),
        .ret_cmd(ret_cmd), .slow(slow), .instr_done(instr_done), .long_call_to_vector(long_call_to_vector),
        .return_from_interrupt(return_from_interrupt));
    task automatic check(input logic [17:0] seen, input logic [17:0] want);
        check_count++;
        if (seen !== want) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge ref_clk) {sfr_wr_en, sfr_addr, sfr_wr_data} = {1'b1, a, v};
        @(negedge ref_clk) sfr_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        @(negedge ref_clk) sfr_addr = a;
        @(negedge ref_clk) check(18'(sfr_rd_data), 18'(v));
    endtask
    task automatic pulse_set(input logic [17:0] m);
        @(negedge ref_clk) flag_set_wr = m;
        @(negedge ref_clk) flag_set_wr = '0;
    endtask
    // bounded wait: a lost request shows as a mismatch, not a hang
    task automatic call(input int i);
        int k;
        k = 0;
        slow = 1'($urandom);
        exp_q.push_back(16'(irq_pkg::vector_base + irq_pkg::vector_stride * i));
        do begin
            @(negedge ref_clk);
            k++;
        end while (!long_call_to_vector && k < 40);
        check(18'(k < 40), 18'h1);
        // the level register follows the call strobe by one edge
        @(negedge ref_clk);
    endtask
    task automatic done(input logic [17:0] m);
        @(negedge ref_clk) {flag_clr_wr, ret_cmd} = {m, 1'b1};
        @(negedge ref_clk) {flag_clr_wr, ret_cmd} = '0;
        repeat (3) @(negedge ref_clk);
    endtask
    // sampled at the falling edge, where call strobe and request both stand settled
    always @(negedge ref_clk) begin
        if (rst_n && long_call_to_vector && irq_request) begin
            if (exp_q.size() == 0) check(18'h1, 18'h0);
            else check(18'(irq_vector), 18'(exp_q.pop_front()));
        end
    end
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h01670A42));
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        rd(8'hA8, 8'h00);
        rd(8'hB8, 8'h80);
        rd(8'hE6, 8'h00);
        rd(8'hE7, 8'h00);
        rd(8'hF7, 8'h00);
        d = 8'($urandom);
        wr(8'hF6, d);
        rd(8'hF6, d);
        wr(8'hF6, 8'h00);
        wr(8'h80, 8'hFF);
        rd(8'h80, 8'h00);
        pulse_set(18'h00020);
        wr(8'hA8, 8'h7F);
        repeat (10) @(negedge ref_clk);
        check(18'({irq_request, pending_flags[5], global_irq_enable}), 18'h2);
        wr(8'hA8, 8'hFF);
        check(18'(global_irq_enable), 18'h1);
        call(5);
        done(18'h0);
        call(5);
        done(18'h00020);
        wr(8'hB8, 8'h40);
        pulse_set(18'h00054);
        call(6);
        done(18'h00040);
        call(2);
        done(18'h00004);
        call(4);
        done(18'h00010);
        pulse_set(18'h00010);
        call(4);
        pulse_set(18'h00040);
        call(6);
        check(18'(service_level), 18'(irq_pkg::lvl_high));
        done(18'h00050);
        done(18'h0);
        wr(8'hE6, 8'hFF);
        wr(8'hE7, 8'h07);
        for (int i = 0; i < 18; i++) begin
            @(negedge ref_clk) src_event = 18'h1 << i;
            @(negedge ref_clk) src_event = '0;
            call(i);
            done(18'h1 << i);
        end
        check(18'(exp_q.size()), 18'h0);
        report_and_stop();
    end
endmodule // two_level_interrupt_handler_bench
`default_nettype wire
